// File: hw/energy_irq_pkg.sv
// Shared constants for the energy event interrupt mask block
package energy_irq_pkg;

  // APB geometry and event count
  localparam int          ADDR_W   = 20;
  localparam int          DATA_W   = 32;
  localparam int          NUM_EVT  = 19;

  // Register indices; byte address is four times the index
  localparam logic [15:0] MASK_IDX       = 16'he50a;
  localparam logic [15:0] STATUS_IDX     = 16'he500;
  localparam logic [15:0] MEAS_MODE_IDX  = 16'he700;
  localparam logic [15:0] PULSE_CFG_IDX  = 16'he610;
  localparam logic [15:0] HALF_CYC_IDX   = 16'he60c;

  // Event and mask bit positions
  localparam int BIT_TOT_ACT_HF   = 0;
  localparam int BIT_FUND_ACT_HF  = 1;
  localparam int BIT_TOT_REA_HF   = 2;
  localparam int BIT_FUND_REA_HF  = 3;
  localparam int BIT_APP_HF       = 4;
  localparam int BIT_LINE_CYC     = 5;
  localparam int BIT_ACT_SIGN_A   = 6;
  localparam int BIT_PSUM1_SIGN   = 9;
  localparam int BIT_REA_SIGN_A   = 10;
  localparam int BIT_PSUM2_SIGN   = 13;
  localparam int BIT_PULSE1_FALL  = 14;
  localparam int BIT_DSP_DONE     = 17;
  localparam int BIT_PSUM3_SIGN   = 18;

  // Measurement mode fields
  localparam int MEASUREMENT_MODE_REG_W          = 8;
  localparam int MEASUREMENT_MODE_REG_ACT_SEL    = 0;
  localparam int MEASUREMENT_MODE_REG_REA_SEL    = 1;

  // Pulse configuration fields
  localparam int PCFG_W           = 12;
  localparam int PCFG_SEL_W       = 3;
  localparam int PCFG_SEL1_LSB    = 0;
  localparam int PCFG_SEL2_LSB    = 3;
  localparam int PCFG_SEL3_LSB    = 6;
  localparam int PCFG_DIS1        = 9;
  localparam int PCFG_DIS2        = 10;
  localparam int PCFG_DIS3        = 11;

  localparam int HALF_CYC_W       = 16;

  // Reset values
  localparam logic [NUM_EVT-1:0]    MASK_RST      = 19'h00000;
  localparam logic [MEASUREMENT_MODE_REG_W-1:0]    MEASUREMENT_MODE_REG_RST     = 8'h00;
  localparam logic [PCFG_W-1:0]     PCFG_RST      = 12'h000;
  localparam logic [HALF_CYC_W-1:0] HALF_CYC_RST  = 16'h0000;

  // Width of the bank of monitored levels
  localparam int MON_W = 27;

endpackage : energy_irq_pkg

// File: hw/level_change_detect.sv
// Change and falling-edge detector for a bank of level inputs
module level_change_detect #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Levels in
  input  wire logic [W-1:0] sample,
  // Change indications, valid in the cycle the new level shows
  output logic      [W-1:0] toggled,
  output logic      [W-1:0] fell
);

  typedef struct packed {
    logic [W-1:0] prev;
    logic         primed;
  } det_state_type;

  det_state_type cur_r;
  det_state_type cur_nxt;

  always_comb begin
    cur_nxt        = cur_r;
    cur_nxt.prev   = sample;
    cur_nxt.primed = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // First sample after reset has no history, so it cannot report a change
  assign toggled = cur_r.primed ? (sample ^ cur_r.prev) : '0;
  assign fell    = cur_r.primed ? (cur_r.prev & ~sample) : '0;

endmodule : level_change_detect

// File: hw/sticky_event_flags.sv
// Sticky event flags, cleared bit by bit; a new event beats its clear
module sticky_event_flags #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Set and clear
  input  wire logic [W-1:0] setEvt,
  input  wire logic [W-1:0] clrEvt,
  // Flags
  output logic      [W-1:0] flags
);

  typedef struct packed {
    logic [W-1:0] flags;
  } flag_state_type;

  flag_state_type cur_r;
  flag_state_type cur_nxt;

  always_comb begin
    cur_nxt       = cur_r;
    cur_nxt.flags = (cur_r.flags & ~clrEvt) | setEvt;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign flags = cur_r.flags;

endmodule : sticky_event_flags

// File: hw/energy_event_irq_enable_mask.sv
// Energy event interrupt enable mask with APB access and event capture
//
// The APB register port was left to the implementer.
module energy_event_irq_enable_mask
  import energy_irq_pkg::*;
(
  // Clock and reset
  input  wire logic                                  clk,
  input  wire logic                                  srst,
  // APB slave
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [energy_irq_pkg::ADDR_W-1:0]     paddr,
  input  wire logic [energy_irq_pkg::DATA_W-1:0]     pwdata,
  input  wire logic [3:0]                            pstrb,
  output logic      [energy_irq_pkg::DATA_W-1:0]     prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  // Energy accumulator bit 30, one per phase A..C
  input  wire logic [2:0]                            totActEnergyBit30,
  input  wire logic [2:0]                            fundActEnergyBit30,
  input  wire logic [2:0]                            totReaEnergyBit30,
  input  wire logic [2:0]                            fundReaEnergyBit30,
  input  wire logic [2:0]                            appEnergyBit30,
  // Power signs per phase A..C, high when negative
  input  wire logic [2:0]                            totActSign,
  input  wire logic [2:0]                            fundActSign,
  input  wire logic [2:0]                            totReaSign,
  input  wire logic [2:0]                            fundReaSign,
  // Sign of the summed powers of each pulse path 1..3
  input  wire logic [2:0]                            pulseSumSign,
  // Pulse generator levels before the disable gate, active low
  input  wire logic [2:0]                            pulseRaw,
  // Single-cycle completion strobes
  input  wire logic                                  lineCycleDone,
  input  wire logic                                  dspPassDone,
  // To the energy and pulse datapaths
  output logic      [energy_irq_pkg::HALF_CYC_W-1:0] halfCycleCount,
  output logic      [energy_irq_pkg::PCFG_SEL_W-1:0] pulse1PowerSelect,
  output logic      [energy_irq_pkg::PCFG_SEL_W-1:0] pulse2PowerSelect,
  output logic      [energy_irq_pkg::PCFG_SEL_W-1:0] pulse3PowerSelect,
  output logic      [2:0]                            pulseOut,
  // Interrupt request, active high level
  output logic                                       irq
);

  import energy_irq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [DATA_W-1:0]     rdata;
    logic                  ready;
    logic                  err;
    logic [NUM_EVT-1:0]    mask;
    logic [MEASUREMENT_MODE_REG_W-1:0]    measMode;
    logic [PCFG_W-1:0]     pulseCfg;
    logic [HALF_CYC_W-1:0] halfCycles;
    logic [2:0]            pulseOut;
    logic                  irq;
  } main_state_type;

  main_state_type cur_r;
  main_state_type cur_nxt;

  logic [MON_W-1:0]   monLevels;
  logic [MON_W-1:0]   monToggled;
  logic [MON_W-1:0]   monFell;
  logic [NUM_EVT-1:0] events;
  logic [NUM_EVT-1:0] statusClr;
  logic [NUM_EVT-1:0] status;
  logic [2:0]         actSign;
  logic [2:0]         reaSign;
  logic [2:0]         pulseDis;
  logic [2:0]         pulseGated;
  logic [NUM_EVT-1:0] pending;
  logic               apbDone;
  logic               statusRead;
  logic [DATA_W-1:0]  maskImage;
  logic [DATA_W-1:0]  statusImage;
  logic [DATA_W-1:0]  measModeImage;
  logic [DATA_W-1:0]  pulseCfgImage;
  logic [DATA_W-1:0]  halfCycImage;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  localparam logic [ADDR_W-1:0] MASK_ADDR      = {2'b00, MASK_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] STATUS_ADDR    = {2'b00, STATUS_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] MEAS_MODE_ADDR = {2'b00, MEAS_MODE_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] PULSE_CFG_ADDR = {2'b00, PULSE_CFG_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] HALF_CYC_ADDR  = {2'b00, HALF_CYC_IDX, 2'b00};

  function automatic logic [DATA_W-1:0] mergeBytes(
    input logic [DATA_W-1:0] oldVal,
    input logic [DATA_W-1:0] newVal,
    input logic [3:0]        strb
  );
    logic [DATA_W-1:0] res;
    res = oldVal;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = newVal[8*b +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  function automatic logic addrHit(input logic [ADDR_W-1:0] a);
    return (a == MASK_ADDR) || (a == STATUS_ADDR) || (a == MEAS_MODE_ADDR) ||
           (a == PULSE_CFG_ADDR) || (a == HALF_CYC_ADDR);
  endfunction : addrHit

  // Unused upper bits of every register read back as zero
  assign maskImage     = {{(DATA_W-NUM_EVT){1'b0}}, cur_r.mask};
  assign statusImage   = {{(DATA_W-NUM_EVT){1'b0}}, status};
  assign measModeImage = {{(DATA_W-MEASUREMENT_MODE_REG_W){1'b0}}, cur_r.measMode};
  assign pulseCfgImage = {{(DATA_W-PCFG_W){1'b0}}, cur_r.pulseCfg};
  assign halfCycImage  = {{(DATA_W-HALF_CYC_W){1'b0}}, cur_r.halfCycles};

  assign apbDone    = psel && penable && cur_r.ready;
  // A status read clears only what its setup captured; later events survive
  assign statusRead = apbDone && !pwrite && (paddr == STATUS_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Event sources

  // Sign sources follow the mode bits; flipping a mode bit may itself show as a change
  for (genvar ph = 0; ph < 3; ph++) begin : g_sign_src
    assign actSign[ph] = cur_r.measMode[MEASUREMENT_MODE_REG_ACT_SEL] ? fundActSign[ph] : totActSign[ph];
    assign reaSign[ph] = cur_r.measMode[MEASUREMENT_MODE_REG_REA_SEL] ? fundReaSign[ph] : totReaSign[ph];
  end

  // Lanes, lsb first: five energy kinds, active and reactive signs, path sums,
  // raw pulses; three lanes each, phase A or path one lowest
  assign monLevels = {pulseRaw,
                      pulseSumSign,
                      reaSign,
                      actSign,
                      appEnergyBit30,
                      fundReaEnergyBit30,
                      totReaEnergyBit30,
                      fundActEnergyBit30,
                      totActEnergyBit30};

  // Reset parks every lane's history, so no edge is seen on the first cycle
  level_change_detect #(
    .W (MON_W)
  ) u_detect (
    .clk     (clk),
    .srst    (srst),
    .sample  (monLevels),
    .toggled (monToggled),
    .fell    (monFell)
  );

  always_comb begin
    events                  = '0;
    events[BIT_TOT_ACT_HF]  = |monToggled[2:0];
    events[BIT_FUND_ACT_HF] = |monToggled[5:3];
    events[BIT_TOT_REA_HF]  = |monToggled[8:6];
    events[BIT_FUND_REA_HF] = |monToggled[11:9];
    events[BIT_APP_HF]      = |monToggled[14:12];
    events[BIT_LINE_CYC]    = lineCycleDone;
    events[BIT_ACT_SIGN_A +: 3] = monToggled[17:15];
    events[BIT_REA_SIGN_A +: 3] = monToggled[20:18];
    events[BIT_PSUM1_SIGN]  = monToggled[21];
    events[BIT_PSUM2_SIGN]  = monToggled[22];
    events[BIT_PSUM3_SIGN]  = monToggled[23];
    // Taken before the disable gate so a parked pin still interrupts
    events[BIT_PULSE1_FALL +: 3] = monFell[26:24];
    events[BIT_DSP_DONE]    = dspPassDone;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags

  // Flags latch regardless of the mask
  sticky_event_flags #(
    .W (NUM_EVT)
  ) u_flags (
    .clk    (clk),
    .srst   (srst),
    .setEvt (events),
    .clrEvt (statusClr),
    .flags  (status)
  );

  // One enable gate per event bit; the flag itself never depends on it
  for (genvar e = 0; e < NUM_EVT; e++) begin : g_pending
    assign pending[e] = status[e] & cur_r.mask[e];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse outputs

  assign pulseDis = {cur_r.pulseCfg[PCFG_DIS3], cur_r.pulseCfg[PCFG_DIS2],
                     cur_r.pulseCfg[PCFG_DIS1]};

  // Gate sits after the edge detector, so a parked pin still raises its event
  for (genvar ch = 0; ch < 3; ch++) begin : g_pulse_gate
    // Disabled pins rest high, the inactive level
    assign pulseGated[ch] = pulseRaw[ch] | pulseDis[ch];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file and outputs

  always_comb begin
    logic setup;
    logic done;
    logic [DATA_W-1:0] merged;
    setup     = psel && !penable;
    done      = apbDone;
    merged    = '0;
    statusClr = '0;
    cur_nxt   = cur_r;

    if (done) begin
      cur_nxt.ready = 1'b0;
      cur_nxt.err   = 1'b0;
    end

    // Read data is sampled at setup so it is stable through the access phase
    if (setup) begin
      cur_nxt.ready = 1'b1;
      cur_nxt.err   = !addrHit(paddr);
      cur_nxt.rdata = '0;
      if (!pwrite) begin
        unique case (paddr)
          MASK_ADDR:      cur_nxt.rdata = maskImage;
          STATUS_ADDR:    cur_nxt.rdata = statusImage;
          MEAS_MODE_ADDR: cur_nxt.rdata = measModeImage;
          PULSE_CFG_ADDR: cur_nxt.rdata = pulseCfgImage;
          HALF_CYC_ADDR:  cur_nxt.rdata = halfCycImage;
          default:        cur_nxt.rdata = '0;
        endcase
      end
    end

    if (statusRead) begin
      statusClr = cur_r.rdata[NUM_EVT-1:0];
    end

    if (done && pwrite) begin
      unique case (paddr)
        MASK_ADDR: begin
          merged = mergeBytes(maskImage, pwdata, pstrb);
          cur_nxt.mask = merged[NUM_EVT-1:0];
        end
        MEAS_MODE_ADDR: begin
          merged = mergeBytes(measModeImage, pwdata, pstrb);
          cur_nxt.measMode = merged[MEASUREMENT_MODE_REG_W-1:0];
        end
        PULSE_CFG_ADDR: begin
          merged = mergeBytes(pulseCfgImage, pwdata, pstrb);
          cur_nxt.pulseCfg = merged[PCFG_W-1:0];
        end
        HALF_CYC_ADDR: begin
          merged = mergeBytes(halfCycImage, pwdata, pstrb);
          cur_nxt.halfCycles = merged[HALF_CYC_W-1:0];
        end
        default: begin
          merged = '0;
        end
      endcase
    end

    cur_nxt.pulseOut = pulseGated;

    cur_nxt.irq = |pending;
  end

  // Pins park high in reset so the outside never sees a false pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      cur_r            <= '0;
      cur_r.mask       <= MASK_RST;
      cur_r.measMode   <= MEASUREMENT_MODE_REG_RST;
      cur_r.pulseCfg   <= PCFG_RST;
      cur_r.halfCycles <= HALF_CYC_RST;
      cur_r.pulseOut   <= 3'h7;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign prdata            = cur_r.rdata;
  assign pready            = cur_r.ready;
  assign pslverr           = cur_r.err;
  assign irq               = cur_r.irq;
  assign pulseOut          = cur_r.pulseOut;
  assign halfCycleCount    = cur_r.halfCycles;
  assign pulse1PowerSelect = cur_r.pulseCfg[PCFG_SEL1_LSB +: PCFG_SEL_W];
  assign pulse2PowerSelect = cur_r.pulseCfg[PCFG_SEL2_LSB +: PCFG_SEL_W];
  assign pulse3PowerSelect = cur_r.pulseCfg[PCFG_SEL3_LSB +: PCFG_SEL_W];

endmodule : energy_event_irq_enable_mask

// File: sim/energy_irq_properties.sv
// Port-level assertions for the energy event interrupt mask
module energy_irq_properties
  import energy_irq_pkg::*;
(
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  srst,
  // APB
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [ADDR_W-1:0]     paddr,
  input wire logic [DATA_W-1:0]     prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // Pulses, datapath controls, interrupt
  input wire logic [2:0]            pulseRaw,
  input wire logic [2:0]            pulseOut,
  input wire logic [PCFG_SEL_W-1:0] pulse1PowerSelect,
  input wire logic [PCFG_SEL_W-1:0] pulse2PowerSelect,
  input wire logic [PCFG_SEL_W-1:0] pulse3PowerSelect,
  input wire logic [HALF_CYC_W-1:0] halfCycleCount,
  input wire logic                  irq
);
  localparam logic [ADDR_W-1:0] PCFG_A = {2'b00, PULSE_CFG_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] HALF_A = {2'b00, HALF_CYC_IDX, 2'b00};
  wire done = psel && penable && pready;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////
  setup_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  error_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  reset_clear_a: assert property ($fell(srst) |-> !irq && !pready && pulseOut == 3'b111
    && halfCycleCount == '0)
    else $error("outputs not cleared by reset");
  pulse_follow_a: assert property (!$past(srst) |-> (~pulseOut & $past(pulseRaw)) == 3'b000)
    else $error("pulse output low without raw pulse");
  select_write_a: assert property ($changed({pulse1PowerSelect, pulse2PowerSelect,
    pulse3PowerSelect}) |-> $past(srst) || $past(done && pwrite && paddr == PCFG_A))
    else $error("power select moved without write");
  half_write_a: assert property ($changed(halfCycleCount)
    |-> $past(srst) || $past(done && pwrite && paddr == HALF_A))
    else $error("half cycle count moved without write");
  rdata_hold_a: assert property ($changed(prdata) |-> pready || $past(srst))
    else $error("read data changed outside answer");
  irq_hold_a: assert property ($fell(irq) |-> $past(done, 2) || $past(srst) || $past(srst, 2))
    else $error("irq dropped without access");
  cover property (pslverr);
  cover property ($rose(irq));
  cover property (pready && pwrite);
endmodule : energy_irq_properties

bind energy_event_irq_enable_mask energy_irq_properties i_props (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pulseRaw(pulseRaw),
  .pulseOut(pulseOut), .pulse1PowerSelect(pulse1PowerSelect),
  .pulse2PowerSelect(pulse2PowerSelect), .pulse3PowerSelect(pulse3PowerSelect),
  .halfCycleCount(halfCycleCount), .irq(irq));

// File: sim/energy_event_irq_enable_mask_tb.sv
// Self-checking bench for the energy event interrupt mask
module energy_event_irq_enable_mask_tb
  import energy_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [19:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0]  pstrb = '0;
  logic        pready, pslverr, irq, lineDone = 0, dspDone = 0;
  logic [2:0]  enTa = 0, enFa = 0, enTr = 0, enFr = 0, enAp = 0, sgTa = 0, sgTr = 0;
  logic [2:0]  sgFa = 3'b111, sgFr = 3'b111, sgSum = 0, pRaw = 3'b111;
  logic [2:0]  pOut, sel1, sel2, sel3;
  logic [15:0] halfCyc;
  int          nErrors = 0, comparisons = 0;

  always #5 clk = ~clk;

  energy_event_irq_enable_mask i_dut (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .totActEnergyBit30(enTa), .fundActEnergyBit30(enFa),
    .totReaEnergyBit30(enTr), .fundReaEnergyBit30(enFr), .appEnergyBit30(enAp),
    .totActSign(sgTa), .fundActSign(sgFa), .totReaSign(sgTr), .fundReaSign(sgFr),
    .pulseSumSign(sgSum), .pulseRaw(pRaw), .lineCycleDone(lineDone),
    .dspPassDone(dspDone), .halfCycleCount(halfCyc), .pulse1PowerSelect(sel1),
    .pulse2PowerSelect(sel2), .pulse3PowerSelect(sel3), .pulseOut(pOut), .irq(irq));
  ////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("errors %0d comparisons %0d", nErrors, comparisons);
    if (nErrors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d,
                     input logic [3:0] st, input logic [31:0] e, input logic er);
    int i;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    pstrb <= st;
    @(posedge clk);
    penable <= 1;
    // Bounded wait: a missing answer ends the run
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      nErrors++;
      $display("[FAIL] %0t no pready", $time);
      finish_test();
    end
    if (!w) chk(prdata, e);
    chk(pslverr, er);
    psel <= 0;
    penable <= 0;
  endtask : apb

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    apb(1, idx, d, 4'hf, 0, 0);
  endtask : wr

  task automatic rd(input logic [15:0] idx, input logic [31:0] e);
    apb(0, idx, 0, 4'hf, e, 0);
  endtask : rd

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_n

  // One event per mask bit; strobes and pulse falls last one cycle
  task automatic stim(input int b);
    @(posedge clk);
    case (b)
      0: enTa[0] <= ~enTa[0];
      1: enFa[1] <= ~enFa[1];
      2: enTr[2] <= ~enTr[2];
      3: enFr[0] <= ~enFr[0];
      4: enAp[1] <= ~enAp[1];
      5: lineDone <= 1;
      6, 7, 8: sgTa[b-6] <= ~sgTa[b-6];
      9: sgSum[0] <= ~sgSum[0];
      13: sgSum[1] <= ~sgSum[1];
      18: sgSum[2] <= ~sgSum[2];
      10, 11, 12: sgTr[b-10] <= ~sgTr[b-10];
      14, 15, 16: pRaw[b-14] <= 0;
      default: dspDone <= 1;
    endcase
    @(posedge clk);
    lineDone <= 0;
    dspDone <= 0;
    pRaw <= 3'b111;
  endtask : stim
  ////////////////////////////////////////////////////////////
  task automatic reset_values;
    rd(MASK_IDX, 0);
    rd(STATUS_IDX, 0);
    rd(MEAS_MODE_IDX, 0);
    rd(PULSE_CFG_IDX, 0);
    rd(HALF_CYC_IDX, 0);
    apb(0, 16'h0100, 0, 4'hf, 0, 1);
    chk(irq, 0);
    chk(pOut, 3'b111);
  endtask : reset_values

  task automatic mask_bits;
    wr(MASK_IDX, 32'hffffffff);
    rd(MASK_IDX, 32'h0007ffff);
    wr(MASK_IDX, 0);
    apb(1, MASK_IDX, 32'hffffffff, 4'h1, 0, 0);
    rd(MASK_IDX, 32'h000000ff);
    wr(MASK_IDX, 32'hffffffff);
  endtask : mask_bits

  task automatic each_event;
    for (int b = 0; b < 19; b++) begin
      stim(b);
      #1;
      if (b >= 14 && b <= 16) chk(pOut, 3'b111 ^ (3'b001 << (b - 14)));
      wait_n(2);
      chk(irq, 1);
      rd(STATUS_IDX, 32'h1 << b);
      wait_n(2);
      chk(irq, 0);
    end
  endtask : each_event

  // Signs already agree, so the source switch itself stays quiet
  task automatic mode_select;
    wr(MEAS_MODE_IDX, 3);
    rd(MEAS_MODE_IDX, 3);
    rd(STATUS_IDX, 0);
    @(posedge clk);
    sgTa[1] <= ~sgTa[1];
    sgTr[2] <= ~sgTr[2];
    wait_n(3);
    rd(STATUS_IDX, 0);
    @(posedge clk);
    sgFa[1] <= ~sgFa[1];
    sgFr[2] <= ~sgFr[2];
    wait_n(3);
    rd(STATUS_IDX, 32'h1080);
  endtask : mode_select

  task automatic pulse_cfg;
    wr(PULSE_CFG_IDX, 32'hfd5);
    rd(PULSE_CFG_IDX, 32'hfd5);
    chk(sel1, 5);
    chk(sel2, 2);
    chk(sel3, 7);
    wr(HALF_CYC_IDX, 32'h1234);
    rd(HALF_CYC_IDX, 32'h1234);
    chk(halfCyc, 32'h1234);
    stim(15);
    #1;
    chk(pOut, 3'b111);
    wait_n(1);
    rd(STATUS_IDX, 32'h8000);
  endtask : pulse_cfg

  task automatic masked;
    wr(MASK_IDX, 0);
    stim(17);
    wait_n(3);
    chk(irq, 0);
    rd(STATUS_IDX, 32'h20000);
    wr(STATUS_IDX, 32'hffffffff);
    rd(STATUS_IDX, 0);
    stim(5);
    wait_n(3);
    chk(irq, 0);
    wr(MASK_IDX, 32'h20);
    wait_n(2);
    chk(irq, 1);
    rd(STATUS_IDX, 32'h20);
    wait_n(2);
    chk(irq, 0);
  endtask : masked

  initial begin
    repeat (12) @(posedge clk);
    srst <= 0;
    reset_values();
    mask_bits();
    each_event();
    mode_select();
    pulse_cfg();
    masked();
    finish_test();
  end
endmodule : energy_event_irq_enable_mask_tb
